/* common/tfc_pkg.sv */
// package: constants, carriers and state types of the three-channel timer
// How it works
// - a starting channel drives its pins to the preset initial levels
// - match flag sets as the counter leaves the matching value
// - capture copies the counter, then sets the match flag one cycle later
// - wrap flag sets on up-wrap from all ones or down-wrap from zero
// - a flag clears only by a read showing 1, then a written 0
// - nine separate requests, three per channel, each while its flag and its enable are 1
// - match A may request DMA instead; then no CPU interrupt for it
// - reset priority ch0 A first to ch2 wrap last; channel order programmable
// - counter clear beats a counter write in the same access cycle
// - a word counter write beats a coincident increment
// - byte counter write in setup or access drops the increment
// - general register write beats and suppresses a coincident compare match
// - a counter write beats counting but the wrap flag still sets
// - a general register read returns the value from before a capture
// - capture clear with increment clears; old count goes to the register
// - capture beats a coincident general register write
// - clear on match happens on leaving the match, period N plus one
// - in paired mode simultaneous A and B matches are suppressed
package tfc_pkg;
  localparam int CH_N = 3;
  localparam int SRC_N = 9;
  localparam int SRC_PER_CH = 3;
  localparam int SRC_A = 0;
  localparam int SRC_WRAP = 2;
  localparam int MODE_W = 8;
  // register byte addresses
  localparam logic [7:0] START_OFS = 8'h00;
  localparam logic [7:0] LEVEL_OFS = 8'h04;
  localparam logic [7:0] PRIO_OFS = 8'h08;
  localparam logic [7:0] DMA_OFS = 8'h0c;
  localparam logic [7:0] IEN_OFS = 8'h10;
  localparam logic [7:0] FLAG_OFS = 8'h14;
  localparam logic [7:0] MODE_OFS = 8'h18;
  localparam logic [7:0] CH_BASE = 8'h20;
  localparam logic [7:0] CH_END = 8'h50;
  localparam logic [3:0] CNT_SUB = 4'h0;
  localparam logic [3:0] GRA_SUB = 4'h4;
  localparam logic [3:0] GRB_SUB = 4'h8;
  // reset channel order 0, 1, 2 in two-bit slots
  localparam logic [5:0] PRIO_RST = 6'h24;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef struct packed {
    logic cap_b;
    logic cap_a;
    logic pair;
    logic down;
    logic clr_b;
    logic clr_a;
  } tfc_mode_type;

  typedef struct packed {
    logic wr_cnt;
    logic busy_byte;
    logic wr_gra;
    logic wr_grb;
    logic [1:0] be;
    logic [15:0] wdata;
  } tfc_cpu_type;

  typedef struct packed {
    logic match_a;
    logic match_b;
    logic wrap;
  } tfc_evt_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] general_register_a;
    logic [15:0] general_register_b;
  } tfc_view_type;

  typedef struct packed {
    tfc_view_type v;
    tfc_evt_type evt;
  } tfc_chan_type;

  typedef struct packed {
    logic [2:0] run;
    logic [5:0] level;
    logic [5:0] prio;
    logic [2:0] dma_sel;
    logic [8:0] ien;
    logic [8:0] flag;
    logic [8:0] armed;
    tfc_mode_type [2:0] mode;
    logic [2:0] sa1;
    logic [2:0] sa2;
    logic [2:0] pa;
    logic [2:0] sb1;
    logic [2:0] sb2;
    logic [2:0] pb;
    logic [2:0] out_a;
    logic [2:0] out_b;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [8:0] irq;
    logic [2:0] dma;
    logic any;
    logic [3:0] vec;
  } tfc_top_type;

  // merge the enabled byte lanes of a write into a 16-bit value
  function automatic logic [15:0] put_bytes(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] be);
    put_bytes = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction
endpackage

/* src/tfc_channel.sv */
// module: one timer channel, counter and two general registers
`timescale 1ns/100ps
`default_nettype none
module tfc_channel (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic cap_a_i,
  input wire logic cap_b_i,
  input wire tfc_pkg::tfc_mode_type mode_i,
  input wire tfc_pkg::tfc_cpu_type cpu_i,
  output tfc_pkg::tfc_evt_type evt_o,
  output tfc_pkg::tfc_view_type view_o
);
  tfc_pkg::tfc_chan_type st;
  tfc_pkg::tfc_chan_type next_st;
  logic step, raw_a, raw_b, cm_a, cm_b, ca, cb, clr, wrap;

  // =====================================================
  // events
  assign step = tick_i & run_i;
  assign ca = cap_a_i & mode_i.cap_a;
  assign cb = cap_b_i & mode_i.cap_b;
  // match seen on the count pulse that leaves the value
  assign raw_a = step & (st.v.cnt == st.v.general_register_a) & ~mode_i.cap_a & ~cpu_i.wr_gra;
  assign raw_b = step & (st.v.cnt == st.v.general_register_b) & ~mode_i.cap_b & ~cpu_i.wr_grb;
  assign cm_a = raw_a & ~(mode_i.pair & raw_b);
  assign cm_b = raw_b & ~(mode_i.pair & raw_a);
  assign clr = ((cm_a | ca) & mode_i.clr_a) | ((cm_b | cb) & mode_i.clr_b);
  assign wrap = step & ~clr & (mode_i.down ? st.v.cnt == tfc_pkg::CNT_ZERO
                                           : st.v.cnt == tfc_pkg::CNT_MAX);

  // =====================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.evt.match_a = cm_a | ca;
    next_st.evt.match_b = cm_b | cb;
    next_st.evt.wrap = wrap;
    if (clr) begin
      next_st.v.cnt = tfc_pkg::CNT_ZERO;
    end else if (cpu_i.wr_cnt) begin
      next_st.v.cnt = tfc_pkg::put_bytes(st.v.cnt, cpu_i.wdata, cpu_i.be);
    end else if (step & ~cpu_i.busy_byte) begin
      next_st.v.cnt = mode_i.down ? st.v.cnt - tfc_pkg::CNT_ONE
                                  : st.v.cnt + tfc_pkg::CNT_ONE;
    end
    // capture takes the pre-clear count and beats a write
    if (ca) begin
      next_st.v.general_register_a = st.v.cnt;
    end else if (cpu_i.wr_gra) begin
      next_st.v.general_register_a = tfc_pkg::put_bytes(st.v.general_register_a, cpu_i.wdata, cpu_i.be);
    end
    if (cb) begin
      next_st.v.general_register_b = st.v.cnt;
    end else if (cpu_i.wr_grb) begin
      next_st.v.general_register_b = tfc_pkg::put_bytes(st.v.general_register_b, cpu_i.wdata, cpu_i.be);
    end
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt_o = st.evt;
  assign view_o = st.v;

  // =====================================================
  // checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  match_clear_a: assert property (
    (step && st.v.cnt == st.v.general_register_a && mode_i.clr_a && !mode_i.cap_a && !mode_i.pair
     && !cpu_i.wr_gra) |=> (st.v.cnt == tfc_pkg::CNT_ZERO && st.evt.match_a))
    else $error("match A did not clear the counter");
  wrap_up_a: assert property (
    (step && !mode_i.down && st.v.cnt == tfc_pkg::CNT_MAX && !clr) |=> st.evt.wrap)
    else $error("up wrap not flagged");
  word_write_a: assert property (
    (cpu_i.wr_cnt && cpu_i.be == 2'h3 && !clr) |=> st.v.cnt == $past(cpu_i.wdata))
    else $error("word write lost to increment");
  clear_wins_a: assert property (
    (clr && cpu_i.wr_cnt) |=> st.v.cnt == tfc_pkg::CNT_ZERO)
    else $error("counter write beat clear");
  cap_beats_a: assert property (
    (ca && cpu_i.wr_gra) |=> st.v.general_register_a == $past(st.v.cnt))
    else $error("register write beat capture");
endmodule // tfc_channel
`default_nettype wire

/* src/tfc_timer.sv */
// module: three-channel timer flags, requests, contention and APB slave
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tfc_timer (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [2:0] count_tick_i,
  input wire logic [2:0] capture_a_i,
  input wire logic [2:0] capture_b_i,
  output logic [2:0] out_a_o,
  output logic [2:0] out_b_o,
  output logic [8:0] irq_o,
  output logic [2:0] dma_req_o,
  output logic irq_any_o,
  output logic [3:0] irq_vec_o
);
  tfc_pkg::tfc_top_type st;
  tfc_pkg::tfc_top_type next_st;
  tfc_pkg::tfc_view_type view [tfc_pkg::CH_N];
  tfc_pkg::tfc_evt_type evt [tfc_pkg::CH_N];
  tfc_pkg::tfc_cpu_type cpu [tfc_pkg::CH_N];
  logic [2:0] cap_a_edge;
  logic [2:0] cap_b_edge;
  logic [7:0] ch_off;
  logic [1:0] ch_idx;
  logic [3:0] sub;
  logic is_ch, ch_hit, fix_hit, hit;
  logic setup, acc, wr_acc, flag_wr, flag_rd;
  logic [31:0] rd_val;
  logic [8:0] set_ev;
  logic [8:0] clr_ev;

  // =====================================================
  // capture pin edges, read only after the second flop
  assign cap_a_edge = st.sa2 & ~st.pa;
  assign cap_b_edge = st.sb2 & ~st.pb;

  // =====================================================
  // address decode
  assign ch_off = paddr_i - tfc_pkg::CH_BASE;
  assign ch_idx = ch_off[5:4];
  assign sub = ch_off[3:0];
  assign is_ch = (paddr_i >= tfc_pkg::CH_BASE) && (paddr_i < tfc_pkg::CH_END);
  assign ch_hit = is_ch && (sub == tfc_pkg::CNT_SUB || sub == tfc_pkg::GRA_SUB
                            || sub == tfc_pkg::GRB_SUB);
  always_comb begin
    case (paddr_i)
      tfc_pkg::START_OFS,
      tfc_pkg::LEVEL_OFS,
      tfc_pkg::PRIO_OFS,
      tfc_pkg::DMA_OFS,
      tfc_pkg::IEN_OFS,
      tfc_pkg::FLAG_OFS,
      tfc_pkg::MODE_OFS: fix_hit = 1'b1;
      default: fix_hit = 1'b0;
    endcase
  end
  assign hit = fix_hit | ch_hit;

  // bus phases: the access cycle is the second cycle of a transfer
  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i & st.ready;
  assign wr_acc = acc & pwrite_i & ~st.slverr & (|pstrb_i);
  assign flag_wr = wr_acc & (paddr_i == tfc_pkg::FLAG_OFS);
  assign flag_rd = acc & ~pwrite_i & (paddr_i == tfc_pkg::FLAG_OFS);

  // =====================================================
  // read mux, sampled in the setup cycle
  always_comb begin
    rd_val = 32'h0;
    case (paddr_i)
      tfc_pkg::START_OFS: rd_val[2:0] = st.run;
      tfc_pkg::LEVEL_OFS: rd_val[5:0] = st.level;
      tfc_pkg::PRIO_OFS: rd_val[5:0] = st.prio;
      tfc_pkg::DMA_OFS: rd_val[2:0] = st.dma_sel;
      tfc_pkg::IEN_OFS: rd_val[8:0] = st.ien;
      tfc_pkg::FLAG_OFS: rd_val[8:0] = st.flag;
      tfc_pkg::MODE_OFS: begin
        for (int c = 0; c < tfc_pkg::CH_N; c++) begin
          rd_val[c*tfc_pkg::MODE_W +: 6] = st.mode[c];
        end
      end
      default: begin
        if (ch_hit && ch_idx < 2'd3) begin
          case (sub)
            tfc_pkg::CNT_SUB: rd_val[15:0] = view[ch_idx].cnt;
            tfc_pkg::GRA_SUB: rd_val[15:0] = view[ch_idx].general_register_a;
            default: rd_val[15:0] = view[ch_idx].general_register_b;
          endcase
        end
      end
    endcase
  end

  // =====================================================
  // channels
  genvar g;
  generate
    for (g = 0; g < tfc_pkg::CH_N; g++) begin : gen_ch
      logic sel;
      logic byte_only;
      assign sel = ch_hit && (ch_idx == 2'(g));
      assign byte_only = (pstrb_i[1:0] == 2'h1) || (pstrb_i[1:0] == 2'h2);
      // counter write lands in the access cycle
      assign cpu[g].wr_cnt = wr_acc & sel & (sub == tfc_pkg::CNT_SUB)
                             & (|pstrb_i[1:0]);
      // byte write holds off counting through setup and access
      assign cpu[g].busy_byte = psel_i & pwrite_i & sel & (sub == tfc_pkg::CNT_SUB)
                                & byte_only;
      assign cpu[g].wr_gra = wr_acc & sel & (sub == tfc_pkg::GRA_SUB);
      assign cpu[g].wr_grb = wr_acc & sel & (sub == tfc_pkg::GRB_SUB);
      assign cpu[g].be = pstrb_i[1:0];
      assign cpu[g].wdata = pwdata_i[15:0];
      tfc_channel u_ch (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .tick_i(count_tick_i[g]),
        .run_i(st.run[g]),
        .cap_a_i(cap_a_edge[g]),
        .cap_b_i(cap_b_edge[g]),
        .mode_i(st.mode[g]),
        .cpu_i(cpu[g]),
        .evt_o(evt[g]),
        .view_o(view[g])
      );
      assign set_ev[g*3 +: 3] = {evt[g].wrap, evt[g].match_b, evt[g].match_a};
    end
  endgenerate

  // a flag clears only when armed by an earlier read showing 1
  assign clr_ev = flag_wr ? (st.armed & ~pwdata_i[8:0]) : 9'h0;

  // =====================================================
  // next state
  always_comb begin
    logic found;
    logic [1:0] pc;
    logic req;
    found = 1'b0;
    pc = 2'h0;
    req = 1'b0;
    next_st = st;
    // two-flop synchronisers and edge history
    next_st.sa1 = capture_a_i;
    next_st.sa2 = st.sa1;
    next_st.pa = st.sa2;
    next_st.sb1 = capture_b_i;
    next_st.sb2 = st.sb1;
    next_st.pb = st.sb2;
    // apb handshake: answer in the cycle after setup
    next_st.ready = setup;
    next_st.slverr = setup & ~hit;
    if (setup & ~pwrite_i) begin
      next_st.rdata = rd_val;
    end
    // control register writes
    if (wr_acc) begin
      case (paddr_i)
        tfc_pkg::START_OFS: next_st.run = pwdata_i[2:0];
        tfc_pkg::LEVEL_OFS: begin
          for (int c = 0; c < tfc_pkg::CH_N; c++) begin
            if (!st.run[c]) begin
              next_st.level[2*c +: 2] = pwdata_i[2*c +: 2];
            end
          end
        end
        tfc_pkg::PRIO_OFS: next_st.prio = pwdata_i[5:0];
        tfc_pkg::DMA_OFS: next_st.dma_sel = pwdata_i[2:0];
        tfc_pkg::IEN_OFS: next_st.ien = pwdata_i[8:0];
        tfc_pkg::MODE_OFS: begin
          for (int c = 0; c < tfc_pkg::CH_N; c++) begin
            next_st.mode[c] = pwdata_i[c*tfc_pkg::MODE_W +: 6];
          end
        end
        default: ;
      endcase
    end
    // starting channel takes its preset pin levels
    for (int c = 0; c < tfc_pkg::CH_N; c++) begin
      if (!st.run[c] && next_st.run[c]) begin
        next_st.out_a[c] = st.level[2*c];
        next_st.out_b[c] = st.level[2*c+1];
      end
    end
    // read of the flags arms the bits seen as 1, a write disarms
    if (flag_rd) begin
      next_st.armed = st.armed | (st.rdata[8:0] & st.flag);
    end
    // any write disarms, so an old read cannot clear a later event
    if (flag_wr) begin
      next_st.armed = 9'h0;
    end
    // set beats clear in the same cycle
    next_st.flag = (st.flag & ~clr_ev) | set_ev;
    // requests with enable and dma steering
    for (int c = 0; c < tfc_pkg::CH_N; c++) begin
      for (int k = 0; k < tfc_pkg::SRC_PER_CH; k++) begin
        req = st.flag[c*3+k] & st.ien[c*3+k];
        if (k == tfc_pkg::SRC_A && st.dma_sel[c]) begin
          next_st.dma[c] = req;
          next_st.irq[c*3+k] = 1'b0;
        end else begin
          next_st.irq[c*3+k] = req;
          if (k == tfc_pkg::SRC_A) begin
            next_st.dma[c] = 1'b0;
          end
        end
      end
    end
    // highest pending source by channel order, A, B, wrap inside
    next_st.vec = 4'h0;
    for (int s = 0; s < tfc_pkg::CH_N; s++) begin
      pc = st.prio[2*s +: 2];
      // slot value 3 names no channel and is skipped
      if (pc != 2'h3) begin
        for (int k = 0; k < tfc_pkg::SRC_PER_CH; k++) begin
          if (!found && next_st.irq[pc*3+k]) begin
            found = 1'b1;
            next_st.vec = 4'(pc*3+k);
          end
        end
      end
    end
    next_st.any = found;
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.prio <= tfc_pkg::PRIO_RST;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================
  // outputs, all from flops
  assign prdata_o = st.rdata;
  assign pready_o = st.ready;
  assign pslverr_o = st.slverr;
  assign out_a_o = st.out_a;
  assign out_b_o = st.out_b;
  assign irq_o = st.irq;
  assign dma_req_o = st.dma;
  assign irq_any_o = st.any;
  assign irq_vec_o = st.vec;

  // =====================================================
  // checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence start0_s;
    !st.run[0] ##1 st.run[0];
  endsequence
  sequence cap1_s;
    cap_a_edge[1] && st.mode[1].cap_a;
  endsequence
  sequence rd_setup_s;
    psel_i && !penable_i && !pwrite_i;
  endsequence

  start_level_a: assert property (
    start0_s |-> (out_a_o[0] == $past(st.level[0]) && out_b_o[0] == $past(st.level[1])))
    else $error("start did not load initial pin level");
  capture_flag_a: assert property (
    cap1_s |=> ##1 (st.flag[3] && view[1].general_register_a == $past(view[1].cnt, 2)))
    else $error("capture did not set flag or copy count");
  flag_clear_a: assert property (
    |($past(st.flag) & ~st.flag) |-> $past(flag_wr))
    else $error("flag dropped without clearing write");
  irq_level_a: assert property (
    (st.flag[1] && st.ien[1]) |=> irq_o[1])
    else $error("match B request missing");
  dma_steer_a: assert property (
    (st.flag[0] && st.ien[0] && st.dma_sel[0]) |=> (dma_req_o[0] && !irq_o[0]))
    else $error("dma source also raised interrupt");
  prio_reset_a: assert property (
    (st.prio == tfc_pkg::PRIO_RST && st.flag[0] && st.ien[0] && !st.dma_sel[0])
    |=> (irq_any_o && irq_vec_o == 4'h0))
    else $error("channel 0 match A not first");
  irq_mask_a: assert property (
    !st.ien[2] |=> !irq_o[2])
    else $error("masked source requested");
  read_hold_a: assert property (
    rd_setup_s |=> (pready_o && prdata_o == $past(rd_val)))
    else $error("read data not from setup cycle");

  // =====================================================
  // register side effects and request routing
  sequence busy_level_wr_s;
    wr_acc && paddr_i == tfc_pkg::LEVEL_OFS && st.run[0];
  endsequence
  sequence start_wr_s;
    wr_acc && paddr_i == tfc_pkg::START_OFS;
  endsequence
  sequence ch2_first_s;
    st.prio[1:0] == 2'h2 && st.flag[8] && st.ien[8] && !(|st.flag[7:6]);
  endsequence

  level_hold_a: assert property (
    busy_level_wr_s |=> st.level[1:0] == $past(st.level[1:0]))
    else $error("initial level changed while running");
  level_free_a: assert property (
    (wr_acc && paddr_i == tfc_pkg::LEVEL_OFS && !st.run[1])
    |=> st.level[3:2] == $past(pwdata_i[3:2]))
    else $error("initial level of stopped channel not written");
  run_write_a: assert property (
    start_wr_s |=> st.run == $past(pwdata_i[2:0]))
    else $error("run bits not written");
  flag_stand_a: assert property (
    (st.flag[0] && !flag_wr) |=> st.flag[0])
    else $error("flag dropped without a write");
  unarmed_keep_a: assert property (
    (flag_wr && !st.armed[0] && st.flag[0]) |=> st.flag[0])
    else $error("unarmed flag cleared");
  armed_clear_a: assert property (
    (flag_wr && st.armed[0] && !pwdata_i[0] && !set_ev[0]) |=> !st.flag[0])
    else $error("armed flag not cleared");
  wrap_irq_a: assert property (
    (st.flag[8] && st.ien[8]) |=> (irq_o[8] && irq_any_o))
    else $error("wrap request missing");
  vec_order_a: assert property (
    ch2_first_s |=> irq_vec_o == 4'h8)
    else $error("channel order not applied");
  err_reply_a: assert property (
    (psel_i && !penable_i && !hit) |=> (pready_o && pslverr_o))
    else $error("unmapped access not refused");
  ready_pulse_a: assert property (
    pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  rdata_keep_a: assert property (
    !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data changed without a read");
endmodule // tfc_timer
`default_nettype wire

/* testbench/tfc_pin_model.sv */
// partner model: capture pin pulses as the far side drives them
`timescale 1ns/100ps
`default_nettype none
module tfc_pin_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [2:0] fire_i,
  output logic [2:0] pin_o
);
  logic [2:0] [2:0] left;
  // =========================================
  // pulse generation
  // each fire request holds its pin high four clocks, wider than the minimum width
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      left <= '0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (fire_i[c]) begin
          left[c] <= 3'h4;
        end else if (left[c] != 3'h0) begin
          left[c] <= left[c] - 3'h1;
        end
      end
    end
  end
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      pin_o[c] = (left[c] != 3'h0);
    end
  end
endmodule // tfc_pin_model
`default_nettype wire

/* testbench/testbench.sv */
// testbench: register-level tests of the three-channel timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] tick = 3'h0;
  logic [2:0] fire = 3'h0;
  logic [2:0] cap_a;
  logic [31:0] prdata;
  logic pready, pslverr, irq_any;
  logic [2:0] out_a, out_b, dma_req;
  logic [8:0] irq;
  logic [3:0] irq_vec;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int compares = 0;
  // =========================================
  // clock, design and partner
  initial forever #2.5 sys_clk = ~sys_clk;
  tfc_timer u_dut (.sys_clk_i(sys_clk), .reset_i(reset), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .count_tick_i(tick),
    .capture_a_i(cap_a), .capture_b_i(3'h0), .out_a_o(out_a), .out_b_o(out_b),
    .irq_o(irq), .dma_req_o(dma_req), .irq_any_o(irq_any), .irq_vec_o(irq_vec));
  tfc_pin_model u_pins (.sys_clk_i(sys_clk), .reset_i(reset), .fire_i(fire), .pin_o(cap_a));
  // =========================================
  // bus tasks; ts and ta put count pulses in the setup and access cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
      input logic [2:0] ts = 3'h0, input logic [2:0] ta = 3'h0);
    @(posedge sys_clk);
    paddr <= a; pwdata <= d; pstrb <= s; pwrite <= 1'b1; psel <= 1'b1; tick <= ts;
    @(posedge sys_clk);
    penable <= 1'b1; tick <= ta;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0; tick <= 3'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    paddr <= a; pwrite <= 1'b0; psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] ch);
    @(posedge sys_clk) tick <= ch;
    @(posedge sys_clk) tick <= 3'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic clr_flags();
    rdr(tfc_pkg::FLAG_OFS);
    wr(tfc_pkg::FLAG_OFS, 32'h0);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // =========================================
  // watchdog
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  // =========================================
  // tests
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rdr(tfc_pkg::PRIO_OFS);
    `CHK("prio reset", 32'h24, rd)
    rdr(8'hfc);
    `CHK("unmapped err", 1'b1, er)
    // initial levels written while stopped, then start
    wr(tfc_pkg::LEVEL_OFS, 32'h3);
    wr(tfc_pkg::START_OFS, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK("pin a0", 1'b1, out_a[0])
    `CHK("pin b0", 1'b1, out_b[0])
    wr(tfc_pkg::LEVEL_OFS, 32'h0);
    rdr(tfc_pkg::LEVEL_OFS);
    `CHK("level while running", 32'h3, rd)
    // compare match with clear on A
    wr(tfc_pkg::MODE_OFS, 32'h1);
    wr(tfc_pkg::IEN_OFS, 32'h1ff);
    wr(tfc_pkg::CH_BASE + 8'h4, 32'h5);
    wr(tfc_pkg::CH_BASE, 32'h5);
    repeat (4) @(posedge sys_clk);
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("no flag on equal", 32'h0, rd)
    pulse(3'h1);
    rdr(tfc_pkg::CH_BASE);
    `CHK("clear on leaving match", 32'h0, rd)
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("match flag", 32'h1, rd)
    `CHK("irq a0", 1'b1, irq[0])
    // a write of ones disarms, so the following 0 must not clear
    wr(tfc_pkg::FLAG_OFS, 32'h1ff);
    wr(tfc_pkg::FLAG_OFS, 32'h0);
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("flag kept unarmed", 32'h1, rd)
    wr(tfc_pkg::FLAG_OFS, 32'h0);
    repeat (2) @(posedge sys_clk);
    `CHK("irq cleared", 9'h0, irq)
    // wrap, then write against wrap and increment
    wr(tfc_pkg::MODE_OFS, 32'h0);
    wr(tfc_pkg::CH_BASE, 32'hffff);
    pulse(3'h1);
    rdr(tfc_pkg::CH_BASE);
    `CHK("wrap count", 32'h0, rd)
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("wrap flag", 32'h4, rd)
    wr(tfc_pkg::FLAG_OFS, 32'h0);
    wr(tfc_pkg::CH_BASE, 32'hffff);
    wr(tfc_pkg::CH_BASE, 32'h1234, 4'hf, 3'h0, 3'h1);
    rdr(tfc_pkg::CH_BASE);
    `CHK("word write wins", 32'h1234, rd)
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("wrap flag on write", 32'h4, rd)
    wr(tfc_pkg::FLAG_OFS, 32'h0);
    wr(tfc_pkg::CH_BASE, 32'hab00, 4'h2, 3'h1, 3'h1);
    rdr(tfc_pkg::CH_BASE);
    `CHK("byte write", 32'hab34, rd)
    // match A steered to dma, then gated by enable
    wr(tfc_pkg::DMA_OFS, 32'h1);
    wr(tfc_pkg::CH_BASE + 8'h4, 32'hab34);
    pulse(3'h1);
    `CHK("dma req", 1'b1, dma_req[0])
    `CHK("no cpu irq", 1'b0, irq[0])
    wr(tfc_pkg::IEN_OFS, 32'h1fe);
    repeat (2) @(posedge sys_clk);
    `CHK("dma gated", 1'b0, dma_req[0])
    // priority between channel 0 match and channel 2 wrap
    wr(tfc_pkg::IEN_OFS, 32'h1ff);
    wr(tfc_pkg::DMA_OFS, 32'h0);
    wr(tfc_pkg::START_OFS, 32'h5);
    wr(tfc_pkg::CH_BASE + 8'h20, 32'hffff);
    pulse(3'h4);
    `CHK("vec reset order", 4'h0, irq_vec)
    `CHK("irq any", 1'b1, irq_any)
    wr(tfc_pkg::PRIO_OFS, 32'h06);
    repeat (2) @(posedge sys_clk);
    `CHK("vec new order", 4'h8, irq_vec)
    // register write in access cycle suppresses the match
    clr_flags();
    wr(tfc_pkg::CH_BASE + 8'h4, 32'hab35);
    wr(tfc_pkg::CH_BASE + 8'h4, 32'h0, 4'hf, 3'h0, 3'h1);
    repeat (4) @(posedge sys_clk);
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("match suppressed", 32'h0, rd)
    rdr(tfc_pkg::CH_BASE + 8'h4);
    `CHK("register written", 32'h0, rd)
    // paired matches at once are dropped; a down count wraps from zero
    wr(tfc_pkg::MODE_OFS, 32'h8);
    wr(tfc_pkg::CH_BASE, 32'h0);
    pulse(3'h1);
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("paired match dropped", 32'h0, rd)
    wr(tfc_pkg::MODE_OFS, 32'h4);
    wr(tfc_pkg::CH_BASE, 32'h0);
    pulse(3'h1);
    rdr(tfc_pkg::CH_BASE);
    `CHK("down wrap count", 32'hffff, rd)
    clr_flags();
    `CHK("down wrap flags", 32'h7, rd)
    // capture with clear on channel 1 against a coincident count pulse
    wr(tfc_pkg::MODE_OFS, 32'h1100);
    wr(tfc_pkg::START_OFS, 32'h7);
    wr(tfc_pkg::CH_BASE + 8'h10, 32'h0777);
    @(posedge sys_clk) fire <= 3'h2;
    @(posedge sys_clk) fire <= 3'h0;
    repeat (2) @(posedge sys_clk);
    tick <= 3'h2; // count pulse in the cycle the synced edge is seen
    @(posedge sys_clk) tick <= 3'h0;
    repeat (8) @(posedge sys_clk);
    rdr(tfc_pkg::CH_BASE + 8'h14);
    `CHK("captured value", 32'h0777, rd)
    rdr(tfc_pkg::CH_BASE + 8'h10);
    `CHK("cleared by capture", 32'h0, rd)
    rdr(tfc_pkg::FLAG_OFS);
    `CHK("capture flag", 32'h8, rd)
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
